// ---- design/pic_pkg.sv ----
package pic_pkg;

    // ****************************************************************
    // source counts and widths
    // ****************************************************************
    localparam int PIC_N_EXT = 8;
    localparam int PIC_N_INT = 72;
    localparam int PIC_N_SRC = 80;
    localparam int PIC_N_FLD = 30;
    localparam int PIC_LVL_W = 3;
    localparam int PIC_VEC_W = 7;
    localparam int PIC_ADR_W = 16;

    // ****************************************************************
    // fixed vector numbers and reset values
    // ****************************************************************
    localparam logic [6:0] PIC_VEC_NMI = 7'h07;
    localparam logic [6:0] PIC_VEC_EXT0 = 7'h10;
    localparam logic [2:0] PIC_LVL_MAX = 3'h7;
    localparam logic [2:0] PIC_FLD_RST = 3'h7;
    localparam logic [1:0] PIC_MODE_RST = 2'h0;
    localparam logic [1:0] PIC_MODE_BITS_0 = 2'h0;
    localparam logic [1:0] PIC_MODE_BITS_2 = 2'h2;
    localparam logic [1:0] PIC_ADR_LSB = 2'h0;
    localparam logic [6:0] PIC_ADR_MSB = 7'h00;

    // ****************************************************************
    // control modes
    // ****************************************************************
    typedef enum logic [1:0] {
        PIC_MODE0,
        PIC_MODE2,
        PIC_MODE_BAD
    } pic_mode_t;

    // ****************************************************************
    // priority field of each external request pin
    // ****************************************************************
    localparam logic [4:0] PIC_EXT_FLD [PIC_N_EXT] = '{
        5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04, 5'h04
    };

    // ****************************************************************
    // vector number of each internal request, ascending
    // ****************************************************************
    localparam logic [6:0] PIC_INT_VEC [PIC_N_INT] = '{
        7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D,
        7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
        7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
        7'h30, 7'h31, 7'h32, 7'h33, 7'h34,
        7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
        7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h46,
        7'h48, 7'h49, 7'h4A, 7'h4B,
        7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56, 7'h57,
        7'h58, 7'h59, 7'h5A, 7'h5B,
        7'h5C, 7'h5D, 7'h5E, 7'h60, 7'h61, 7'h62,
        7'h64, 7'h65, 7'h66, 7'h67,
        7'h78, 7'h79, 7'h7A, 7'h7B, 7'h7C, 7'h7D, 7'h7E, 7'h7F
    };

    // ****************************************************************
    // priority field of each internal request, same order
    // ****************************************************************
    localparam logic [4:0] PIC_INT_FLD [PIC_N_INT] = '{
        5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h09,
        5'h0A, 5'h0A, 5'h0A, 5'h0A, 5'h0A,
        5'h0B, 5'h0B, 5'h0B, 5'h0B, 5'h0C, 5'h0C, 5'h0C, 5'h0C,
        5'h0D, 5'h0D, 5'h0D, 5'h0D, 5'h0D,
        5'h0E, 5'h0E, 5'h0E, 5'h0E, 5'h0F, 5'h0F, 5'h0F, 5'h0F,
        5'h10, 5'h10, 5'h10, 5'h11, 5'h11, 5'h11,
        5'h12, 5'h12, 5'h12, 5'h12,
        5'h13, 5'h13, 5'h13, 5'h13, 5'h14, 5'h14, 5'h14, 5'h14,
        5'h15, 5'h15, 5'h15, 5'h15,
        5'h16, 5'h16, 5'h16, 5'h16, 5'h16, 5'h16,
        5'h17, 5'h17, 5'h17, 5'h17,
        5'h1C, 5'h1C, 5'h1C, 5'h1C, 5'h1D, 5'h1D, 5'h1D, 5'h1D
    };

endpackage

// ---- design/pic_gate.sv ----
`timescale 1ns/100ps
`default_nettype none

module pic_gate #(
    parameter int LVL_W = 3
) (
    // request and its programmed level
    input wire logic req_i,
    input wire logic [LVL_W-1:0] field_i,
    // mode and cpu mask state
    input wire pic_pkg::pic_mode_t mode_i,
    input wire logic cpu_mask_bit_i,
    input wire logic [LVL_W-1:0] mask_level_i,
    // result
    output logic eligible_o,
    output logic [LVL_W-1:0] level_o
);

    // ****************************************************************
    // masking of one maskable source
    // ****************************************************************

    // mode 0 uses one mask bit, mode 2 a level compare
    always_comb begin
        eligible_o = 1'b0;
        level_o = '0;
        case (mode_i)
            pic_pkg::PIC_MODE0: begin
                eligible_o = req_i && !cpu_mask_bit_i;
            end
            pic_pkg::PIC_MODE2: begin
                eligible_o = req_i && (field_i > mask_level_i);
                level_o = field_i;
            end
            default: begin
                eligible_o = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- design/pic_pick.sv ----
`timescale 1ns/100ps
`default_nettype none

module pic_pick #(
    parameter int N = 80,
    parameter int LVL_W = 3,
    parameter int VEC_W = 7
) (
    // candidates, in ascending vector order
    input wire logic elig_i [N],
    input wire logic [LVL_W-1:0] level_i [N],
    input wire logic [VEC_W-1:0] vec_i [N],
    // winner
    output logic found_o,
    output logic [LVL_W-1:0] level_o,
    output logic [VEC_W-1:0] vec_o
);

    // ****************************************************************
    // highest level wins, first (lowest vector) on a tie
    // ****************************************************************

    // strict compare keeps the earlier, lower vector on equal levels
    always_comb begin
        found_o = 1'b0;
        level_o = '0;
        vec_o = '0;
        for (int i = 0; i < N; i++) begin
            if (elig_i[i] && (!found_o || level_i[i] > level_o)) begin
                found_o = 1'b1;
                level_o = level_i[i];
                vec_o = vec_i[i];
            end
        end
    end

endmodule

`default_nettype wire

// ---- design/pic_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module pic_top #(
    parameter int N_INT = 72,
    parameter int N_EXT = 8
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // request sources
    input wire logic nmi_i,
    input wire logic [N_EXT-1:0] ext_request_pin_i,
    input wire logic [N_INT-1:0] int_req_i,
    // mode bits of the system control register
    input wire logic mode_wr_i,
    input wire logic ctrl_mode_hi_bit_i,
    input wire logic ctrl_mode_lo_bit_i,
    // priority field access
    input wire logic field_wr_i,
    input wire logic [4:0] field_sel_i,
    input wire logic [2:0] field_data_i,
    output logic [2:0] field_rd_o,
    // cpu mask state
    input wire logic cpu_mask_bit_i,
    input wire logic [2:0] mask_level_bits_i,
    // cpu handshake
    input wire logic cpu_take_i,
    output logic irq_o,
    output logic [6:0] vector_num_o,
    output logic [15:0] vector_addr_o,
    output logic [2:0] irq_level_o,
    output logic taken_o,
    output logic [6:0] taken_vec_o,
    // status
    output logic [1:0] mode_bits_o,
    output logic mode_bad_o,
    output logic nmi_pending_o
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************

    // table sizes are fixed by the source map
    if (N_INT != pic_pkg::PIC_N_INT || N_EXT != pic_pkg::PIC_N_EXT) begin
        $error("pic_top: source counts must match the vector map");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************

    localparam int NS = pic_pkg::PIC_N_SRC;

    logic [1:0] mode_reg;
    logic [2:0] field_reg [pic_pkg::PIC_N_FLD];
    logic [2:0] field_rd_reg;
    logic nmi_prev_reg;
    logic nmi_flag_reg;
    logic irq_reg;
    logic [6:0] vec_reg;
    logic [2:0] lvl_reg;
    logic taken_reg;
    logic [6:0] taken_vec_reg;
    pic_pkg::pic_mode_t mode_dec;
    logic src_req [NS];
    logic [2:0] src_field [NS];
    logic [6:0] src_vec [NS];
    logic src_elig [NS];
    logic [2:0] src_lvl [NS];
    logic pick_found;
    logic [2:0] pick_lvl;
    logic [6:0] pick_vec;
    logic nmi_edge;
    logic nmi_clear;
    logic irq_next;
    logic [6:0] vec_next;
    logic [2:0] lvl_next;

    // ****************************************************************
    // mode bits
    // ****************************************************************

    // mode field written by software, mode 0 after reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mode_reg <= pic_pkg::PIC_MODE_RST;
        end else if (ce_i && mode_wr_i) begin
            mode_reg <= {ctrl_mode_hi_bit_i, ctrl_mode_lo_bit_i};
        end
    end

    // decode two bits into a control mode
    always_comb begin
        case (mode_reg)
            pic_pkg::PIC_MODE_BITS_0: mode_dec = pic_pkg::PIC_MODE0;
            pic_pkg::PIC_MODE_BITS_2: mode_dec = pic_pkg::PIC_MODE2;
            default: mode_dec = pic_pkg::PIC_MODE_BAD;
        endcase
    end

    assign mode_bits_o = mode_reg;
    assign mode_bad_o = (mode_dec == pic_pkg::PIC_MODE_BAD);

    // ****************************************************************
    // priority fields
    // ****************************************************************

    // three-bit fields, all at the top level after reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            for (int i = 0; i < pic_pkg::PIC_N_FLD; i++) begin
                field_reg[i] <= pic_pkg::PIC_FLD_RST;
            end
        end else if (ce_i && field_wr_i) begin
            if (field_sel_i < 5'(pic_pkg::PIC_N_FLD)) begin
                field_reg[field_sel_i] <= field_data_i;
            end
        end
    end

    // readback of the selected field, zero when out of range
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            field_rd_reg <= 3'h0;
        end else if (ce_i) begin
            if (field_sel_i < 5'(pic_pkg::PIC_N_FLD)) begin
                field_rd_reg <= field_reg[field_sel_i];
            end else begin
                field_rd_reg <= 3'h0;
            end
        end
    end

    assign field_rd_o = field_rd_reg;

    // ****************************************************************
    // non-maskable request
    // ****************************************************************

    // rising edge of the pin latches a pending flag
    assign nmi_edge = nmi_i && !nmi_prev_reg;
    assign nmi_clear = cpu_take_i && irq_reg && vec_reg == pic_pkg::PIC_VEC_NMI;

    // pin history for edge sensing
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            nmi_prev_reg <= 1'b0;
        end else if (ce_i) begin
            nmi_prev_reg <= nmi_i;
        end
    end

    // new edge wins over a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            nmi_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (nmi_edge) begin
                nmi_flag_reg <= 1'b1;
            end else if (nmi_clear) begin
                nmi_flag_reg <= 1'b0;
            end
        end
    end

    assign nmi_pending_o = nmi_flag_reg;

    // ****************************************************************
    // source map
    // ****************************************************************

    // pins first, then internal sources, ascending vector order
    always_comb begin
        for (int i = 0; i < N_EXT; i++) begin
            src_req[i] = ext_request_pin_i[i];
            src_vec[i] = pic_pkg::PIC_VEC_EXT0 + 7'(i);
            src_field[i] = field_reg[pic_pkg::PIC_EXT_FLD[i]];
        end
        for (int i = 0; i < N_INT; i++) begin
            src_req[N_EXT + i] = int_req_i[i];
            src_vec[N_EXT + i] = pic_pkg::PIC_INT_VEC[i];
            src_field[N_EXT + i] = field_reg[pic_pkg::PIC_INT_FLD[i]];
        end
    end

    // ****************************************************************
    // per-source masking
    // ****************************************************************

    // one gate per maskable source
    for (genvar g = 0; g < NS; g++) begin : gen_gate
        pic_gate #(
            .LVL_W(pic_pkg::PIC_LVL_W)
        ) u_gate (
            .req_i(src_req[g]),
            .field_i(src_field[g]),
            .mode_i(mode_dec),
            .cpu_mask_bit_i(cpu_mask_bit_i),
            .mask_level_i(mask_level_bits_i),
            .eligible_o(src_elig[g]),
            .level_o(src_lvl[g])
        );
    end

    // ****************************************************************
    // arbitration
    // ****************************************************************

    // highest eligible level, lowest vector among equals
    pic_pick #(
        .N(NS),
        .LVL_W(pic_pkg::PIC_LVL_W),
        .VEC_W(pic_pkg::PIC_VEC_W)
    ) u_pick (
        .elig_i(src_elig),
        .level_i(src_lvl),
        .vec_i(src_vec),
        .found_o(pick_found),
        .level_o(pick_lvl),
        .vec_o(pick_vec)
    );

    // nmi ahead of every maskable winner
    always_comb begin
        if (nmi_flag_reg) begin
            irq_next = 1'b1;
            vec_next = pic_pkg::PIC_VEC_NMI;
            lvl_next = pic_pkg::PIC_LVL_MAX;
        end else begin
            irq_next = pick_found;
            vec_next = pick_vec;
            lvl_next = pick_lvl;
        end
    end

    // ****************************************************************
    // request to the cpu
    // ****************************************************************

    // registered winner, withdrawn for one cycle after a take
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
            vec_reg <= 7'h00;
            lvl_reg <= 3'h0;
        end else if (ce_i) begin
            irq_reg <= irq_next && !(cpu_take_i && irq_reg);
            vec_reg <= vec_next;
            lvl_reg <= lvl_next;
        end
    end

    assign irq_o = irq_reg;
    assign vector_num_o = vec_reg;
    assign irq_level_o = lvl_reg;
    assign vector_addr_o = {pic_pkg::PIC_ADR_MSB, vec_reg,
        pic_pkg::PIC_ADR_LSB};

    // ****************************************************************
    // taken vector
    // ****************************************************************

    // a take only counts while a request stands
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            taken_reg <= 1'b0;
            taken_vec_reg <= 7'h00;
        end else if (ce_i) begin
            taken_reg <= cpu_take_i && irq_reg;
            if (cpu_take_i && irq_reg) begin
                taken_vec_reg <= vec_reg;
            end
        end
    end

    assign taken_o = taken_reg;
    assign taken_vec_o = taken_vec_reg;

endmodule

`default_nettype wire

// ---- bench/pic_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module pic_top_sva #(
    parameter int N_INT = 72,
    parameter int N_EXT = 8
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // watched inputs
    input wire logic mode_wr_i,
    input wire logic ctrl_mode_hi_bit_i,
    input wire logic ctrl_mode_lo_bit_i,
    input wire logic cpu_mask_bit_i,
    input wire logic [2:0] mask_level_bits_i,
    input wire logic cpu_take_i,
    // watched outputs
    input wire logic irq_o,
    input wire logic [6:0] vector_num_o,
    input wire logic [15:0] vector_addr_o,
    input wire logic [2:0] irq_level_o,
    input wire logic taken_o,
    input wire logic [6:0] taken_vec_o,
    input wire logic [1:0] mode_bits_o,
    input wire logic mode_bad_o,
    input wire logic nmi_pending_o
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    a_addr_map: assert property (
        irq_o |-> vector_addr_o == {7'h00, vector_num_o, 2'h0}
    ) else $error("vector address is not four times the vector");
    a_nmi_first: assert property (
        nmi_pending_o && !cpu_take_i |=> irq_o && irq_level_o == 3'h7
            && vector_num_o == pic_pkg::PIC_VEC_NMI
    ) else $error("pending nmi not presented next cycle");
    a_mask_bit_block: assert property (
        (mode_bits_o == 2'h0 && cpu_mask_bit_i && !nmi_pending_o) [*2]
            |-> !irq_o
    ) else $error("request passed with mask bit set");
    a_level_gate: assert property (
        irq_o && mode_bits_o == 2'h2 && $past(mode_bits_o) == 2'h2
            && vector_num_o != pic_pkg::PIC_VEC_NMI
            |-> irq_level_o > $past(mask_level_bits_i)
    ) else $error("level not above mask level");
    a_take_ack: assert property (
        cpu_take_i && irq_o |=> taken_o && taken_vec_o == $past(vector_num_o)
    ) else $error("take not acknowledged with its vector");
    a_take_drop: assert property (
        taken_o |-> !irq_o ##1 !taken_o
    ) else $error("taken pulse too long or request not dropped");
    a_mode_load: assert property (
        mode_wr_i |=> mode_bits_o ==
            $past({ctrl_mode_hi_bit_i, ctrl_mode_lo_bit_i})
    ) else $error("mode bits not loaded");
    a_bad_flag: assert property (
        mode_bad_o == mode_bits_o[0]
    ) else $error("prohibited mode flag wrong");
    a_bad_block: assert property (
        mode_bad_o && $past(mode_bad_o) && irq_o
            |-> vector_num_o == pic_pkg::PIC_VEC_NMI
    ) else $error("request passed in prohibited mode");

    // main scenarios reached
    c_nmi_taken: cover property (taken_o && taken_vec_o == 7'h07);
    c_level_five: cover property (irq_o && irq_level_o == 3'h5);
    c_bad_mode: cover property (mode_bad_o && !irq_o);
endmodule

bind pic_top pic_top_sva #(.N_INT(N_INT), .N_EXT(N_EXT)) pic_top_sva_inst (
    .clock_i, .reset_i, .mode_wr_i, .ctrl_mode_hi_bit_i, .ctrl_mode_lo_bit_i,
    .cpu_mask_bit_i, .mask_level_bits_i, .cpu_take_i, .irq_o, .vector_num_o,
    .vector_addr_o, .irq_level_o, .taken_o, .taken_vec_o, .mode_bits_o,
    .mode_bad_o, .nmi_pending_o
);
`default_nettype wire

// ---- bench/pic_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module pic_cpu_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // controller side
    input wire logic irq_i,
    output logic take_o,
    // bench control
    input wire logic go_i,
    input wire logic [1:0] delay_i
);
    logic [1:0] wait_reg;

    // finish the running instruction, then take a pending request
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            take_o <= 1'b0;
            wait_reg <= 2'h0;
        end else if (take_o) begin
            take_o <= 1'b0;
        end else if (go_i && irq_i) begin
            if (wait_reg == delay_i) begin
                take_o <= 1'b1;
                wait_reg <= 2'h0;
            end else begin
                wait_reg <= wait_reg + 2'h1;
            end
        end else begin
            wait_reg <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_prioritised_interrupt_controller.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_prioritised_interrupt_controller;
    // ********
    // signals
    // ********
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic nmi_i = 1'b0;
    logic [7:0] ext_request_pin_i = 8'h00;
    logic [71:0] int_req_i = '0;
    logic mode_wr_i = 1'b0;
    logic ctrl_mode_hi_bit_i = 1'b0;
    logic ctrl_mode_lo_bit_i = 1'b0;
    logic field_wr_i = 1'b0;
    logic [4:0] field_sel_i = 5'h00;
    logic [2:0] field_data_i = 3'h0;
    logic cpu_mask_bit_i = 1'b0;
    logic [2:0] mask_level_bits_i = 3'h0;
    logic cpu_take_i, go = 1'b0;
    logic [1:0] delay = 2'h0;
    logic irq_o, taken_o, mode_bad_o, nmi_pending_o;
    logic [6:0] vector_num_o, taken_vec_o;
    logic [15:0] vector_addr_o;
    logic [2:0] field_rd_o, irq_level_o;
    logic [1:0] mode_bits_o;
    logic [6:0] exp_q [$];
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    int g_idx [6] = '{0, 6, 32, 38, 42, 64};
    int g_vec [6] = '{24, 32, 64, 72, 80, 120};
    int g_n [6] = '{2, 5, 3, 4, 4, 8};

    always #5 clock_i = ~clock_i;

    pic_top pic_top_inst (
        .clock_i, .reset_i, .ce_i(1'b1), .nmi_i, .ext_request_pin_i,
        .int_req_i, .mode_wr_i, .ctrl_mode_hi_bit_i, .ctrl_mode_lo_bit_i,
        .field_wr_i, .field_sel_i, .field_data_i, .field_rd_o, .cpu_mask_bit_i,
        .mask_level_bits_i, .cpu_take_i, .irq_o, .vector_num_o,
        .vector_addr_o, .irq_level_o, .taken_o, .taken_vec_o, .mode_bits_o,
        .mode_bad_o, .nmi_pending_o
    );

    pic_cpu_model pic_cpu_model_inst (
        .clock_i, .reset_i, .irq_i(irq_o), .take_o(cpu_take_i), .go_i(go),
        .delay_i(delay)
    );

    // ********
    // checking
    // ********
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic note(input bit ok, input string what);
        n_checks++;
        if (!ok) begin
            n_fail++;
            $display("ERROR t=%0t %s", $time, what);
        end
    endtask
    task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp);
        note(got === exp, "vector number");
    endtask
    task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
        note(got === exp, "vector address");
    endtask
    task automatic chk_lvl(input logic [2:0] got, input logic [2:0] exp);
        note(got === exp, "level or field");
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        note(got === exp, "flag");
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            end_of_test();
        end
    end

    // each take pairs with the oldest expected vector
    always @(posedge clock_i) begin
        if (reset_i === 1'b0 && taken_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                note(1'b0, "take with nothing expected");
            end else begin
                chk_vec(taken_vec_o, exp_q.pop_front());
            end
        end
    end

    // ********
    // stimulus
    // ********
    task automatic wr_field(input logic [4:0] s, input logic [2:0] d);
        field_sel_i <= s;
        field_data_i <= d;
        field_wr_i <= 1'b1;
        tick(1);
        field_wr_i <= 1'b0;
        tick(1);
    endtask
    task automatic set_mode(input logic hi, input logic lo);
        ctrl_mode_hi_bit_i <= hi;
        ctrl_mode_lo_bit_i <= lo;
        mode_wr_i <= 1'b1;
        tick(1);
        mode_wr_i <= 1'b0;
        tick(1);
    endtask
    // wait for the request, check it, let the cpu take it, clear sources
    task automatic serve(input logic [6:0] v, input logic [2:0] lv);
        int k;
        k = 0;
        while (irq_o !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        chk_flag(irq_o, 1'b1);
        chk_vec(vector_num_o, v);
        chk_addr(vector_addr_o, {7'h00, v, 2'h0});
        chk_lvl(irq_level_o, lv);
        exp_q.push_back(v);
        delay <= 2'($urandom_range(3));
        go <= 1'b1;
        k = 0;
        while (taken_o !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        go <= 1'b0;
        ext_request_pin_i <= 8'h00;
        int_req_i <= '0;
        tick(3);
    endtask

    initial begin
        int i;
        int j;
        logic [2:0] lv;
        logic [2:0] mk;
        void'($urandom(71242));
        tick(12);
        reset_i <= 1'b0;
        tick(2);
        chk_lvl({1'b0, mode_bits_o}, 3'h0);
        for (i = 0; i < 31; i++) begin
            field_sel_i <= 5'(i);
            tick(2);
            chk_lvl(field_rd_o, (i < 30) ? 3'h7 : 3'h0);
        end
        // mode 0: every pin, then requests from six of the peripheral groups
        for (i = 0; i < 8; i++) begin
            ext_request_pin_i[i] <= 1'b1;
            serve(7'(16 + i), 3'h0);
        end
        for (i = 0; i < 6; i++) begin
            for (j = 0; j < g_n[i]; j++) begin
                int_req_i[g_idx[i] + j] <= 1'b1;
                serve(7'(g_vec[i] + j), 3'h0);
            end
        end
        ext_request_pin_i <= 8'h20;
        int_req_i[0] <= 1'b1;
        serve(7'h15, 3'h0);
        cpu_mask_bit_i <= 1'b1;
        ext_request_pin_i <= 8'h08;
        tick(4);
        chk_flag(irq_o, 1'b0);
        nmi_i <= 1'b1;
        tick(1);
        nmi_i <= 1'b0;
        tick(1);
        chk_flag(nmi_pending_o, 1'b1);
        serve(7'h07, 3'h7);
        chk_flag(nmi_pending_o, 1'b0);
        cpu_mask_bit_i <= 1'b0;
        // mode 2: levels against the mask level
        set_mode(1'b1, 1'b0);
        chk_lvl({1'b0, mode_bits_o}, 3'h2);
        wr_field(5'h00, 3'h2);
        wr_field(5'h05, 3'h5);
        ext_request_pin_i <= 8'h01;
        int_req_i[0] <= 1'b1;
        serve(7'h18, 3'h5);
        wr_field(5'h06, 3'h5);
        int_req_i <= 72'h3;
        serve(7'h18, 3'h5);
        for (i = 0; i < 8; i++) begin
            lv = (i == 1) ? 3'h7 : 3'($urandom_range(7));
            mk = (i == 0) ? lv : (i == 1) ? 3'h6 : 3'($urandom_range(7));
            wr_field(5'h06, lv);
            mask_level_bits_i <= mk;
            int_req_i[1] <= 1'b1;
            if (lv > mk) begin
                serve(7'h19, lv);
            end else begin
                tick(4);
                chk_flag(irq_o, 1'b0);
                int_req_i <= '0;
                tick(2);
            end
        end
        mask_level_bits_i <= 3'h7;
        ext_request_pin_i <= 8'h01;
        nmi_i <= 1'b1;
        tick(1);
        nmi_i <= 1'b0;
        serve(7'h07, 3'h7);
        // every mode pattern, prohibited ones pass nothing
        mask_level_bits_i <= 3'h0;
        ext_request_pin_i <= 8'h01;
        for (i = 0; i < 4; i++) begin
            set_mode(i[1], i[0]);
            tick(2);
            chk_flag(mode_bad_o, i[0]);
            if (i[0]) begin
                chk_flag(irq_o, 1'b0);
            end
        end
        ext_request_pin_i <= 8'h00;
        tick(2);
        chk_flag(exp_q.size() == 0, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
